// *** shared/cth_pkg.sv ***
// constants for the transmit history and block sequencer
package cth_pkg;
    localparam int NUM_BUF = 16;
    localparam int HIST_DEPTH = 7;
    localparam int BLOCK_LAST = 7;
    localparam logic [2:0] MODE_INIT = 3'h0;
    localparam logic [2:0] MODE_BLOCK = 3'h2;
    // register byte offsets
    localparam logic [7:0] OFS_MODULE_CTRL = 8'h00;
    localparam logic [7:0] OFS_BLOCK_CTRL = 8'h04;
    localparam logic [7:0] OFS_BLOCK_DELAY = 8'h08;
    localparam logic [7:0] OFS_LAST_OUT = 8'h0C;
    localparam logic [7:0] OFS_HIST_GET = 8'h10;
    localparam logic [7:0] OFS_TX_REQ = 8'h14;
    localparam logic [7:0] OFS_TX_READY = 8'h18;
    // field positions
    localparam int BIT_TRIGGER = 0;
    localparam int BIT_CLEAR = 1;
    localparam int BIT_MATCH = 8;
    localparam int BIT_OVF = 9;
    localparam int BIT_TXSTAT = 8;
    // reset values
    localparam logic [2:0] RST_MODE = 3'h0;
    localparam logic [7:0] RST_DELAY = 8'h00;
    localparam logic [3:0] NO_ENTRY = 4'hF;
endpackage

// *** sim/cth_can_node_model.sv ***
// behavioural model of the transmit engine
`timescale 1ns/100ps

//==========================================================================
// sender
module cth_can_node_model #(
    parameter int FRAME = 10
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic txSelValid_q,
    input wire logic [3:0] txSelBuf_q,
    output logic txDone,
    output logic txBusy,
    output logic [3:0] txDoneBuf
);
    int cnt;
    logic [3:0] curBuf;
    // done buffer is only meaningful with the pulse; otherwise inverted
    assign txDoneBuf = txDone ? curBuf : ~curBuf;
    // frame on the bus, then a short idle gap before the next one
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cnt <= 0;
            txDone <= 1'b0;
            txBusy <= 1'b0;
            curBuf <= 4'h0;
        end
        else
        begin
            txDone <= 1'b0;
            if (txBusy)
            begin
                cnt <= cnt + 1;
                if (cnt == FRAME)
                begin
                    txBusy <= 1'b0;
                    txDone <= 1'b1;
                    cnt <= 0;
                end
            end
            else if (cnt < 4)
                cnt <= cnt + 1;
            else if (go && txSelValid_q)
            begin
                txBusy <= 1'b1;
                curBuf <= txSelBuf_q;
                cnt <= 0;
            end
        end
    end
endmodule

// *** sim/test_cth_tx_history_auto_block.sv ***
// self-checking bench for the history list and block sequencer
`timescale 1ns/100ps

//==========================================================================
// bench
module test_cth_tx_history_auto_block;
    import cth_pkg::*;
    typedef struct {logic [3:0] b; logic [3:0] e;} cth_row_type;
    logic sys_clk, rst_n, regWrStb, regRdStb, go, txDone, txBusy;
    logic [7:0] regAddr, prevReq;
    logic [31:0] regWrData, regRdData_q;
    logic [3:0] txDoneBuf, txSelBuf_q;
    logic [15:0] txRequest_q;
    logic txSelValid_q;
    logic [3:0] seqBuf[$];
    int error_cnt, num_checks, cyc, gap;
    // send order, and what get reads return after the overwrite
    cth_row_type rows[7] = '{'{4'h8, 4'h8}, '{4'h9, 4'h9}, '{4'hA, 4'hA},
        '{4'hB, 4'hB}, '{4'hC, 4'hC}, '{4'hD, 4'hE}, '{4'hE, 4'h0}};

    cth_tx_history_auto_block #(.DBT_CYCLES(2)) dut_u (.sys_clk(sys_clk),
        .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_q(regRdData_q),
        .txDone(txDone), .txBusy(txBusy), .txDoneBuf(txDoneBuf),
        .bufIdLow(16'h0000), .txRequest_q(txRequest_q),
        .txSelBuf_q(txSelBuf_q), .txSelValid_q(txSelValid_q));
    cth_can_node_model #(.FRAME(10)) node_u (.sys_clk(sys_clk),
        .rst_n(rst_n), .go(go), .txSelValid_q(txSelValid_q),
        .txSelBuf_q(txSelBuf_q), .txDone(txDone), .txBusy(txBusy),
        .txDoneBuf(txDoneBuf));

    // clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // sent-buffer log, block delay gap and hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (txDone)
        begin
            seqBuf.push_back(txDoneBuf);
            gap = 0;
        end
        else
            gap++;
        if (txRequest_q[7:0] != 0 && prevReq == 0 && seqBuf.size() > 0)
            chk(32'(gap >= 6 && gap <= 12), 32'h1);
        prevReq = txRequest_q[7:0];
        if (cyc == 20000)
        begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        #1 chk(regRdData_q & m, e);
    endtask
    task automatic send(input logic [3:0] b);
        int k;
        wr(OFS_TX_REQ, 32'h1 << b);
        for (k = 0; k < 200 && !txDone; k++)
            @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic blk();
        int k;
        seqBuf.delete();
        wr(OFS_BLOCK_CTRL, 32'h1);
        for (k = 0; k < 2000 && seqBuf.size() < 8; k++)
            @(posedge sys_clk);
        repeat (4) @(posedge sys_clk);
        chk(32'(seqBuf.size()), 32'h8);
        for (k = 0; k < 8; k++)
            chk(32'(seqBuf[k]), k);
        rd(OFS_BLOCK_CTRL, 32'h3, 32'h0);
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {regWrStb, regRdStb, regAddr, regWrData, go, rst_n} = '0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        go <= 1'b1;
        rd(OFS_MODULE_CTRL, 32'hFFFF_FFFF, 32'h0);
        rd(OFS_HIST_GET, 32'h300, 32'h100);
        rd(8'hFC, 32'hFFFF_FFFF, 32'h0);
        wr(OFS_TX_READY, 32'hFFFF);
        wr(OFS_MODULE_CTRL, 32'h1);
        foreach (rows[i])
        begin
            send(rows[i].b);
            rd(OFS_LAST_OUT, 32'hF, 32'(rows[i].b));
        end
        for (int i = 0; i < 6; i++)
            rd(OFS_HIST_GET, 32'h20F, 32'h200 | rows[i].e);
        rd(OFS_HIST_GET, 32'h300, 32'h300);
        send(4'h9);
        rd(OFS_HIST_GET, 32'h300, 32'h300);
        wr(OFS_HIST_GET, 32'h0);
        rd(OFS_HIST_GET, 32'h200, 32'h0);
        // abort a request that never reached the bus
        go <= 1'b0;
        wr(OFS_TX_REQ, 32'h8000);
        rd(OFS_TX_REQ, 32'hFFFF, 32'h8000);
        wr(OFS_TX_REQ, 32'h0);
        rd(OFS_TX_REQ, 32'hFFFF, 32'h0);
        rd(OFS_MODULE_CTRL, 32'h100, 32'h0);
        go <= 1'b1;
        // block mode, then clear and run it again from buffer 0
        wr(OFS_MODULE_CTRL, 32'(MODE_BLOCK));
        wr(OFS_BLOCK_DELAY, 32'h3);
        blk();
        rd(OFS_LAST_OUT, 32'hF, 32'h9);
        // abort of a non-block request in block mode, trigger left clear
        go <= 1'b0;
        wr(OFS_TX_REQ, 32'h8000);
        rd(OFS_TX_REQ, 32'hFFFF, 32'h8000);
        rd(OFS_BLOCK_CTRL, 32'h1, 32'h0);
        wr(OFS_TX_REQ, 32'h0);
        rd(OFS_TX_REQ, 32'hFFFF, 32'h0);
        go <= 1'b1;
        // clear only while the trigger reads zero
        wr(OFS_BLOCK_CTRL, 32'h2);
        repeat (3) @(posedge sys_clk);
        rd(OFS_BLOCK_CTRL, 32'h3, 32'h0);
        blk();
        end_sim();
    end
endmodule

// *** src/cth_tx_history_auto_block.sv ***
// transmit history list and automatic block transmission sequencer
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps

//==========================================================================
// What this block does
// - seven-entry history of sent buffer numbers
// - history contents undefined after leaving init
// - last-out read gives entry at writePtr-1
// - record at write pointer, then advance
// - get read gives oldest, advances read pointer
// - match flag when pointers equal
// - overflow at writePtr==readPtr-1, then overwrite last
// - six completions fit; the sixth raises overflow
// - overflow sticky; match not cleared by records while overflow
// - mode 010 selects block transmission
// - block area is buffers 0 to 7
// - trigger requests buffer 0, then ascending
// - wait delay in data bit times between
// - no priority in block; clear trigger after 7
// - ready cleared: skip, stop, clear trigger
// - clear bit resets sequencer, self-clears
// - pending block buffer arbitrated against 8-15
// - block frames not recorded in history
// - request clear aborts, status bit reports
// - zero delay may lag one frame
// - request cleared on successful send
module cth_tx_history_auto_block #(
    parameter int DBT_CYCLES = 100
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData_q,
    // transmit engine side
    input wire logic txDone,
    input wire logic txBusy,
    input wire logic [3:0] txDoneBuf,
    input wire logic [15:0] bufIdLow,
    output logic [15:0] txRequest_q,
    output logic [3:0] txSelBuf_q,
    output logic txSelValid_q
);
    import cth_pkg::*;

    logic [2:0] mode_q;
    logic [7:0] delay_q;
    logic trigger_q, clearBit_q, txStat_q;
    logic [15:0] ready_q;
    logic [3:0] hist_q [HIST_DEPTH];
    logic [2:0] wrPtr_q, rdPtr_q;
    logic match_q, ovf_q;
    logic [2:0] blkPtr_q;
    logic waiting_q;
    logic [7:0] dlyCnt_q;
    logic [$clog2(DBT_CYCLES+1)-1:0] dbtCnt_q;
    logic dbtTick;
    logic wrHit, rdGet;

    // modulo-seven pointer step
    function automatic logic [2:0] ptrInc(input logic [2:0] p);
        return (p == 3'(HIST_DEPTH-1)) ? 3'h0 : p + 3'h1;
    endfunction
    function automatic logic [2:0] ptrDec(input logic [2:0] p);
        return (p == 3'h0) ? 3'(HIST_DEPTH-1) : p - 3'h1;
    endfunction

    assign wrHit = regWrStb;
    assign rdGet = regRdStb && regAddr == OFS_HIST_GET;

    // history recording: only buffers outside the block area when in block
    logic recordEv;
    assign recordEv = txDone && !(mode_q == MODE_BLOCK &&
        txDoneBuf <= 4'(BLOCK_LAST));

    //======================================================================
    // control registers
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            mode_q <= RST_MODE;
            delay_q <= RST_DELAY;
        end
        else if (wrHit && regAddr == OFS_MODULE_CTRL)
            mode_q <= regWrData[2:0];
        else if (wrHit && regAddr == OFS_BLOCK_DELAY)
            delay_q <= regWrData[7:0];
    end

    // buffer ready bits, written by software
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            ready_q <= 16'h0000;
        else if (wrHit && regAddr == OFS_TX_READY)
            ready_q <= regWrData[15:0];
    end

    //======================================================================
    // data bit time divider
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || dbtCnt_q == $bits(dbtCnt_q)'(DBT_CYCLES-1))
            dbtCnt_q <= '0;
        else
            dbtCnt_q <= dbtCnt_q + 1'b1;
    end
    assign dbtTick = dbtCnt_q == $bits(dbtCnt_q)'(DBT_CYCLES-1);

    //======================================================================
    // history store, pointers and flags
    // a mode change leaves entries and pointers alone, so software
    // must treat the store as undefined after leaving init
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            wrPtr_q <= 3'h0;
            rdPtr_q <= 3'h0;
            match_q <= 1'b1;
            ovf_q <= 1'b0;
            for (int i = 0; i < HIST_DEPTH; i++)
                hist_q[i] <= NO_ENTRY;
        end
        else
        begin
            if (recordEv)
            begin
                if (ovf_q)
                    hist_q[ptrDec(wrPtr_q)] <= txDoneBuf;
                else
                begin
                    hist_q[wrPtr_q] <= txDoneBuf;
                    wrPtr_q <= ptrInc(wrPtr_q);
                    if (ptrInc(wrPtr_q) == ptrDec(rdPtr_q))
                        ovf_q <= 1'b1;
                end
            end
            else if (wrHit && regAddr == OFS_HIST_GET &&
                     !regWrData[BIT_OVF])
                ovf_q <= 1'b0;
            if (rdGet && !match_q)
                rdPtr_q <= ptrInc(rdPtr_q);
            // match flag tracks pointer equality; records leave it alone during overflow, get reads can still set it
            if (rdGet && !match_q && ptrInc(rdPtr_q) == wrPtr_q)
                match_q <= 1'b1;
            else if (recordEv && !ovf_q)
                match_q <= 1'b0;
        end
    end

    //======================================================================
    // block sequencer and request flags
    logic blkActive;
    assign blkActive = mode_q == MODE_BLOCK && trigger_q;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            trigger_q <= 1'b0;
            clearBit_q <= 1'b0;
            blkPtr_q <= 3'h0;
            waiting_q <= 1'b0;
            dlyCnt_q <= 8'h00;
            txRequest_q <= 16'h0000;
            txStat_q <= 1'b0;
        end
        else
        begin
            txStat_q <= txBusy;
            if (clearBit_q)
            begin
                blkPtr_q <= 3'h0;
                clearBit_q <= 1'b0;
            end
            if (wrHit && regAddr == OFS_BLOCK_CTRL)
            begin
                trigger_q <= regWrData[BIT_TRIGGER] &&
                    !(txBusy && txRequest_q[blkPtr_q]);
                if (!regWrData[BIT_TRIGGER] && !trigger_q)
                    clearBit_q <= regWrData[BIT_CLEAR];
                if (regWrData[BIT_TRIGGER] && !trigger_q)
                    waiting_q <= 1'b0;
            end
            if (wrHit && regAddr == OFS_TX_REQ)
            begin
                // clearing a request aborts unless it is on the bus
                for (int b = 0; b < NUM_BUF; b++)
                    if (!regWrData[b] && !(txBusy && txSelBuf_q == 4'(b)))
                        txRequest_q[b] <= 1'b0;
                    else if (regWrData[b] && (mode_q != MODE_BLOCK ||
                             b > BLOCK_LAST))
                        txRequest_q[b] <= 1'b1;
            end
            if (txDone)
                txRequest_q[txDoneBuf] <= 1'b0;
            if (blkActive)
            begin
                if (txDone && txDoneBuf == {1'b0, blkPtr_q})
                begin
                    if (blkPtr_q == 3'(BLOCK_LAST))
                    begin
                        trigger_q <= 1'b0;
                        blkPtr_q <= 3'h0;
                    end
                    else
                    begin
                        blkPtr_q <= blkPtr_q + 3'h1;
                        waiting_q <= 1'b1;
                        dlyCnt_q <= delay_q;
                    end
                end
                else if (!ready_q[blkPtr_q] && !txRequest_q[blkPtr_q])
                    trigger_q <= 1'b0;
                else if (!ready_q[blkPtr_q])
                begin
                    txRequest_q[blkPtr_q] <= 1'b0;
                    trigger_q <= 1'b0;
                end
                else if (waiting_q && dlyCnt_q != 8'h00)
                begin
                    if (dbtTick)
                        dlyCnt_q <= dlyCnt_q - 8'h01;
                end
                else if (!txRequest_q[blkPtr_q])
                begin
                    txRequest_q[blkPtr_q] <= 1'b1;
                    waiting_q <= 1'b0;
                end
            end
        end
    end

    //======================================================================
    // next-frame selection: lowest id key, then lowest buffer number
    always_ff @(posedge sys_clk)
    begin
        logic [3:0] best;
        logic found;
        best = 4'h0;
        found = 1'b0;
        for (int b = 0; b < NUM_BUF; b++)
            if (txRequest_q[b] && ready_q[b] &&
                (!found || bufIdLow[b] < bufIdLow[best]))
            begin
                best = 4'(b);
                found = 1'b1;
            end
        if (!rst_n)
        begin
            txSelBuf_q <= 4'h0;
            txSelValid_q <= 1'b0;
        end
        else if (!txBusy)
        begin
            txSelBuf_q <= best;
            txSelValid_q <= found;
        end
    end

    //======================================================================
    // read data, one cycle after the strobe
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !regRdStb)
            regRdData_q <= 32'h0000_0000;
        else
            case (regAddr)
                OFS_MODULE_CTRL: regRdData_q <= {23'h0, txStat_q, 5'h0, mode_q};
                OFS_BLOCK_CTRL: regRdData_q <= {30'h0, clearBit_q, trigger_q};
                OFS_BLOCK_DELAY: regRdData_q <= {24'h0, delay_q};
                OFS_LAST_OUT: regRdData_q <= {28'h0,
                    hist_q[ptrDec(wrPtr_q)]};
                OFS_HIST_GET: regRdData_q <= {22'h0, ovf_q, match_q,
                    4'h0, hist_q[rdPtr_q]};
                OFS_TX_REQ: regRdData_q <= {16'h0, txRequest_q};
                OFS_TX_READY: regRdData_q <= {16'h0, ready_q};
                default: regRdData_q <= 32'h0000_0000;
            endcase
    end

    //======================================================================
    // checks on history pointers and flags
    a_match_equal: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !ovf_q && match_q |-> rdPtr_q == wrPtr_q)
        else $error("match set with unequal pointers");
    a_wrap_range: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wrPtr_q < 3'h7 && rdPtr_q < 3'h7)
        else $error("pointer out of range");
    a_ovf_sticky: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ovf_q && !(wrHit && regAddr == OFS_HIST_GET) |=> ovf_q)
        else $error("overflow dropped without clear");
    a_ovf_set: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        recordEv && !ovf_q && ptrInc(wrPtr_q) == ptrDec(rdPtr_q)
        |=> ovf_q)
        else $error("overflow not raised when full");
    a_block_norec: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        txDone && mode_q == MODE_BLOCK && txDoneBuf < 4'h8
        |=> $stable(wrPtr_q))
        else $error("block frame recorded");
    a_rec_adv: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        recordEv && !ovf_q |=> wrPtr_q == ptrInc($past(wrPtr_q)))
        else $error("write pointer did not advance");
    // read port idles at zero outside the answer cycle
    a_read_idle: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !regRdStb |=> regRdData_q == 32'h0000_0000)
        else $error("read data outside answer cycle");
    // checks on the block sequencer and request flags
    a_last_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        blkActive && txDone && txDoneBuf == 4'h7 && blkPtr_q == 3'h7
        |=> !trigger_q)
        else $error("trigger not cleared after last");
    a_block_single: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        blkActive |-> $countones(txRequest_q[7:0]) <= 1)
        else $error("more than one block request");
    a_done_clears: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        txDone |=> !txRequest_q[$past(txDoneBuf)])
        else $error("request survived completion");
    a_clear_self: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        clearBit_q |=> !clearBit_q && blkPtr_q == 3'h0)
        else $error("clear bit stuck");
    a_mode_block: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        wrHit && regAddr == OFS_MODULE_CTRL
        |=> mode_q == $past(regWrData[2:0]))
        else $error("mode not taken");
endmodule
